// [hw/sfe_front_end.sv]
// serial flash spi front end: pin sampling, decode, read and program paths
`timescale 1ns/1ps
module sfe_front_end #(
  parameter int FIFO_DEPTH = sfe_pkg::FIFO_DEPTH_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SPI_CLK,
  input wire logic CHIP_SEL_N,
  input wire logic HOLD_N,
  input wire logic SERIAL_IN_IO0_I,
  output logic SERIAL_IN_IO0_O,
  output logic SERIAL_IN_IO0_OE,
  input wire logic SERIAL_OUT_IO1_I,
  output logic SERIAL_OUT_IO1_O,
  output logic SERIAL_OUT_IO1_OE,
  input wire logic [sfe_pkg::SECTORS-1:0] PROT_VOLATILE,
  input wire logic [sfe_pkg::SECTORS-1:0] PROT_NONVOL,
  input wire logic BUSY,
  input wire logic [7:0] RD_BYTE,
  output logic RD_FETCH,
  output logic [sfe_pkg::ADDR_W-1:0] RD_ADDR,
  output logic PROG_START,
  output logic [sfe_pkg::ADDR_W-1:0] PROG_ADDR,
  output logic [7:0] PROG_DATA,
  output logic PROG_VALID,
  input wire logic PROG_READY,
  output logic PROG_END,
  output logic PROG_OVERRUN,
  output logic ERASE_REQ,
  output logic [1:0] ERASE_SCOPE,
  output logic [sfe_pkg::ADDR_W-1:0] ERASE_ADDR,
  output logic OTP_LOCKED,
  output logic ACTIVE_POWER,
  output logic STANDBY
);
  import sfe_pkg::*;

  logic [SYNC_W-1:0] pins_q;
  logic sclk, cs_n, hold_n, d0, d1;
  logic rise, fall, hold, cs_fall, cs_rise;
  logic [SECTORS-1:0] prot_map;
  logic [ADDR_W-1:0] a_new;
  logic [7:0] byte_in;
  logic [7:0] rd_src;
  logic [7:0] ld_byte;
  logic [7:0] wr_byte;
  logic is_rd, is_fast, is_dual_rd, is_otp_rd, is_stat;
  logic is_pp, is_dual_pp, is_otp_pp, is_sub, is_sect;
  logic byte_done;
  logic fifo_ready;

  sfe_state_e state_r, state_nxt;
  logic sclk_prev_r, sclk_prev_nxt;
  logic cs_prev_r, cs_prev_nxt;
  logic armed_r, armed_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [4:0] bitcnt_r, bitcnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic wel_r, wel_nxt;
  logic [CNT_W-1:0] bytecnt_r, bytecnt_nxt;
  logic [3:0] outcnt_r, outcnt_nxt;
  logic [7:0] out_sh_r, out_sh_nxt;
  logic drive_r, drive_nxt;
  logic pend_r, pend_nxt;
  logic [7:0] pend_data_r, pend_data_nxt;
  logic prog_act_r, prog_act_nxt;
  logic erase_pend_r, erase_pend_nxt;
  logic [1:0] scope_r, scope_nxt;
  logic [ADDR_W-1:0] eaddr_r, eaddr_nxt;
  logic [7:0] otp_mem_r [OTP_BYTES];
  logic [7:0] otp_mem_nxt [OTP_BYTES];
  logic otp_lock_r, otp_lock_nxt;
  logic io0_o_nxt, io0_oe_nxt, io1_o_nxt, io1_oe_nxt;
  logic rd_fetch_nxt, prog_start_nxt, prog_end_nxt, overrun_nxt;
  logic erase_req_nxt, active_nxt, standby_nxt;
  logic [ADDR_W-1:0] rd_addr_nxt, prog_addr_nxt;

  sfe_sync #(
    .WIDTH(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .d({SERIAL_OUT_IO1_I, SERIAL_IN_IO0_I, HOLD_N, CHIP_SEL_N, SPI_CLK}),
    .q(pins_q)
  );

  sfe_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .in_valid(pend_r),
    .in_ready(fifo_ready),
    .in_data(pend_data_r),
    .out_valid(PROG_VALID),
    .out_ready(PROG_READY),
    .out_data(PROG_DATA)
  );

  // pin decode and edge detection
  always_comb begin
    sclk = pins_q[PIN_SCLK];
    cs_n = pins_q[PIN_CS_N];
    hold_n = pins_q[PIN_HOLD_N];
    d0 = pins_q[PIN_IO0];
    d1 = pins_q[PIN_IO1];
    hold = !hold_n && !cs_n;
    rise = sclk && !sclk_prev_r && !cs_n && !hold;
    fall = !sclk && sclk_prev_r && !cs_n && !hold;
    cs_fall = !cs_n && cs_prev_r;
    cs_rise = cs_n && !cs_prev_r;
    prot_map = PROT_VOLATILE | PROT_NONVOL;
    is_rd = (cmd_r == OP_READ);
    is_fast = (cmd_r == OP_FAST_READ);
    is_dual_rd = (cmd_r == OP_DUAL_OUTPUT_FAST_READ);
    is_otp_rd = (cmd_r == OP_OTP_AREA_READ_CMD);
    is_stat = (cmd_r == OP_STATUS);
    is_pp = (cmd_r == OP_PAGE_PROG);
    is_dual_pp = (cmd_r == OP_DUAL_INPUT_FAST_PROGRAM);
    is_otp_pp = (cmd_r == OP_OTP_AREA_PROGRAM_CMD);
    is_sub = (cmd_r == OP_SUB_ERASE);
    is_sect = (cmd_r == OP_SECT_ERASE);
  end

  // front end state group
  always_comb begin
    byte_in = {sh_r[6:0], d0};
    a_new = {addr_r[ADDR_W-2:0], d0};
    rd_src = RD_BYTE;
    ld_byte = out_sh_r;
    wr_byte = {sh_r[5:0], d1, d0};
    byte_done = 1'b0;
    state_nxt = state_r;
    sclk_prev_nxt = sclk;
    cs_prev_nxt = cs_n;
    armed_nxt = armed_r;
    cmd_nxt = cmd_r;
    sh_nxt = sh_r;
    bitcnt_nxt = bitcnt_r;
    addr_nxt = addr_r;
    wel_nxt = wel_r;
    bytecnt_nxt = bytecnt_r;
    outcnt_nxt = outcnt_r;
    out_sh_nxt = out_sh_r;
    drive_nxt = drive_r;
    pend_nxt = pend_r && !fifo_ready;
    pend_data_nxt = pend_data_r;
    prog_act_nxt = prog_act_r;
    erase_pend_nxt = erase_pend_r;
    scope_nxt = scope_r;
    eaddr_nxt = eaddr_r;
    otp_mem_nxt = otp_mem_r;
    otp_lock_nxt = otp_lock_r;
    io0_o_nxt = SERIAL_IN_IO0_O;
    io1_o_nxt = SERIAL_OUT_IO1_O;
    rd_fetch_nxt = 1'b0;
    rd_addr_nxt = RD_ADDR;
    prog_start_nxt = 1'b0;
    prog_addr_nxt = PROG_ADDR;
    prog_end_nxt = 1'b0;
    erase_req_nxt = 1'b0;
    overrun_nxt = PROG_OVERRUN;
    if (is_stat) begin
      rd_src = {5'h00, otp_lock_r, wel_r, BUSY};
    end else if (is_otp_rd) begin
      rd_src = (addr_r < OTP_LOCK_ADDR) ? otp_mem_r[addr_r[OTP_AW-1:0]]
               : {7'h00, !otp_lock_r};
    end
    if (cs_n) begin
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      if (cs_rise && erase_pend_r) begin
        erase_req_nxt = 1'b1;
        erase_pend_nxt = 1'b0;
        wel_nxt = 1'b0;
      end
      if (cs_rise && prog_act_r) begin
        prog_end_nxt = 1'b1;
        prog_act_nxt = 1'b0;
        wel_nxt = 1'b0;
      end
    end else if (cs_fall) begin
      armed_nxt = 1'b1;
      state_nxt = ST_CMD;
      bitcnt_nxt = '0;
      overrun_nxt = 1'b0;
      erase_pend_nxt = 1'b0;
      prog_act_nxt = 1'b0;
    end else if (rise) begin
      unique case (state_r)
        ST_CMD: begin
          sh_nxt = byte_in;
          bitcnt_nxt = 5'(bitcnt_r + 1'b1);
          if (bitcnt_r == 5'(BYTE_BITS - 1)) begin
            cmd_nxt = byte_in;
            bitcnt_nxt = '0;
            bytecnt_nxt = '0;
            outcnt_nxt = '0;
            state_nxt = ST_DONE;
            if (armed_r) begin
              unique case (byte_in)
                OP_WRITE_EN: wel_nxt = 1'b1;
                OP_WRITE_DIS: wel_nxt = 1'b0;
                OP_STATUS: state_nxt = ST_RDATA;
                OP_BULK_ERASE: begin
                  erase_pend_nxt = wel_r && (prot_map == '0);
                  scope_nxt = SCOPE_BULK;
                  eaddr_nxt = '0;
                end
                OP_READ, OP_FAST_READ, OP_DUAL_OUTPUT_FAST_READ,
                OP_OTP_AREA_READ_CMD, OP_PAGE_PROG,
                OP_DUAL_INPUT_FAST_PROGRAM, OP_OTP_AREA_PROGRAM_CMD,
                OP_SUB_ERASE, OP_SECT_ERASE: state_nxt = ST_ADDR;
                default: state_nxt = ST_DONE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          addr_nxt = a_new;
          bitcnt_nxt = 5'(bitcnt_r + 1'b1);
          if (bitcnt_r == 5'(ADDR_BITS - 1)) begin
            bitcnt_nxt = '0;
            state_nxt = ST_DONE;
            if (is_sub || is_sect) begin
              // sector from the top bits, subsector from the next four
              erase_pend_nxt = wel_r && !prot_map[a_new[ADDR_W-1:SECT_LSB]];
              scope_nxt = is_sub ? SCOPE_SUB : SCOPE_SECT;
              eaddr_nxt = is_sub ? {a_new[ADDR_W-1:SUB_LSB], 12'h000}
                          : {a_new[ADDR_W-1:SECT_LSB], 16'h0000};
            end else if (is_pp || is_dual_pp) begin
              if (wel_r &&
                  !prot_map[a_new[ADDR_W-1:SECT_LSB]]) begin
                state_nxt = ST_WDATA;
                prog_act_nxt = 1'b1;
                prog_start_nxt = 1'b1;
                prog_addr_nxt = a_new;
              end
            end else if (is_otp_pp) begin
              if (wel_r && !otp_lock_r) begin
                state_nxt = ST_WDATA;
                prog_act_nxt = 1'b1;
              end
            end else if (is_rd) begin
              state_nxt = ST_RDATA;
              rd_fetch_nxt = 1'b1;
              rd_addr_nxt = a_new;
            end else begin
              state_nxt = ST_DUMMY;
              rd_fetch_nxt = !is_otp_rd;
              rd_addr_nxt = a_new;
            end
          end
        end
        ST_DUMMY: begin
          bitcnt_nxt = 5'(bitcnt_r + 1'b1);
          if (bitcnt_r == 5'(DUMMY_BITS - 1)) begin
            state_nxt = ST_RDATA;
          end
        end
        ST_WDATA: begin
          if (is_dual_pp) begin
            sh_nxt = wr_byte;
            bitcnt_nxt = 5'(bitcnt_r + 2'h2);
            byte_done = (bitcnt_r == 5'(BYTE_BITS - 2));
          end else begin
            sh_nxt = byte_in;
            wr_byte = byte_in;
            bitcnt_nxt = 5'(bitcnt_r + 1'b1);
            byte_done = (bitcnt_r == 5'(BYTE_BITS - 1));
          end
          if (byte_done) begin
            bitcnt_nxt = '0;
            if (bytecnt_r < CNT_W'(PAGE_BYTES)) begin
              bytecnt_nxt = CNT_W'(bytecnt_r + 1'b1);
              addr_nxt = {addr_r[ADDR_W-1:8], 8'(addr_r[7:0] + 1'b1)};
              if (is_otp_pp) begin
                if (addr_r < OTP_LOCK_ADDR) begin
                  otp_mem_nxt[addr_r[OTP_AW-1:0]] =
                    otp_mem_r[addr_r[OTP_AW-1:0]] & wr_byte;
                end else if (addr_r == OTP_LOCK_ADDR &&
                             !wr_byte[OTP_LOCK_BIT]) begin
                  otp_lock_nxt = 1'b1;
                end
              end else if (pend_r && !fifo_ready) begin
                overrun_nxt = 1'b1;
              end else begin
                pend_nxt = 1'b1;
                pend_data_nxt = wr_byte;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end else if (fall && state_r == ST_RDATA) begin
      drive_nxt = 1'b1;
      if (outcnt_r == '0) begin
        ld_byte = rd_src;
        outcnt_nxt = 4'(BYTE_BITS);
        if (!is_stat) begin
          addr_nxt = ADDR_W'(addr_r + 1'b1);
          rd_fetch_nxt = !is_otp_rd;
          rd_addr_nxt = ADDR_W'(addr_r + 1'b1);
        end
      end else begin
        outcnt_nxt = outcnt_r;
      end
      io1_o_nxt = ld_byte[7];
      if (is_dual_rd) begin
        io0_o_nxt = ld_byte[6];
        out_sh_nxt = {ld_byte[5:0], 2'h0};
        outcnt_nxt = 4'(outcnt_nxt - 2'h2);
      end else begin
        out_sh_nxt = {ld_byte[6:0], 1'b0};
        outcnt_nxt = 4'(outcnt_nxt - 1'b1);
      end
    end
    // output enables follow select, hold and the read phase
    io1_oe_nxt = drive_nxt && !cs_n && !hold
                 && (state_nxt == ST_RDATA);
    io0_oe_nxt = io1_oe_nxt && is_dual_rd;
    active_nxt = !cs_n || BUSY || erase_pend_r
                 || prog_act_r;
    standby_nxt = !active_nxt;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b0;
      armed_r <= 1'b0;
      cmd_r <= 8'h00;
      sh_r <= 8'h00;
      bitcnt_r <= '0;
      addr_r <= '0;
      wel_r <= 1'b0;
      bytecnt_r <= '0;
      outcnt_r <= '0;
      out_sh_r <= 8'h00;
      drive_r <= 1'b0;
      pend_r <= 1'b0;
      pend_data_r <= 8'h00;
      prog_act_r <= 1'b0;
      erase_pend_r <= 1'b0;
      scope_r <= SCOPE_SUB;
      eaddr_r <= '0;
      otp_lock_r <= 1'b0;
      SERIAL_IN_IO0_O <= 1'b0;
      SERIAL_IN_IO0_OE <= 1'b0;
      SERIAL_OUT_IO1_O <= 1'b0;
      SERIAL_OUT_IO1_OE <= 1'b0;
      RD_FETCH <= 1'b0;
      RD_ADDR <= '0;
      PROG_START <= 1'b0;
      PROG_ADDR <= '0;
      PROG_END <= 1'b0;
      PROG_OVERRUN <= 1'b0;
      ERASE_REQ <= 1'b0;
      ACTIVE_POWER <= 1'b0;
      STANDBY <= 1'b1;
    end else begin
      state_r <= state_nxt;
      sclk_prev_r <= sclk_prev_nxt;
      cs_prev_r <= cs_prev_nxt;
      armed_r <= armed_nxt;
      cmd_r <= cmd_nxt;
      sh_r <= sh_nxt;
      bitcnt_r <= bitcnt_nxt;
      addr_r <= addr_nxt;
      wel_r <= wel_nxt;
      bytecnt_r <= bytecnt_nxt;
      outcnt_r <= outcnt_nxt;
      out_sh_r <= out_sh_nxt;
      drive_r <= drive_nxt;
      pend_r <= pend_nxt;
      pend_data_r <= pend_data_nxt;
      prog_act_r <= prog_act_nxt;
      erase_pend_r <= erase_pend_nxt;
      scope_r <= scope_nxt;
      eaddr_r <= eaddr_nxt;
      otp_lock_r <= otp_lock_nxt;
      SERIAL_IN_IO0_O <= io0_o_nxt;
      SERIAL_IN_IO0_OE <= io0_oe_nxt;
      SERIAL_OUT_IO1_O <= io1_o_nxt;
      SERIAL_OUT_IO1_OE <= io1_oe_nxt;
      RD_FETCH <= rd_fetch_nxt;
      RD_ADDR <= rd_addr_nxt;
      PROG_START <= prog_start_nxt;
      PROG_ADDR <= prog_addr_nxt;
      PROG_END <= prog_end_nxt;
      PROG_OVERRUN <= overrun_nxt;
      ERASE_REQ <= erase_req_nxt;
      ACTIVE_POWER <= active_nxt;
      STANDBY <= standby_nxt;
    end
  end

  // otp storage, one byte per entry, erased to all ones
  for (genvar i = 0; i < OTP_BYTES; i++) begin : g_otp
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        otp_mem_r[i] <= OTP_ERASED;
      end else begin
        otp_mem_r[i] <= otp_mem_nxt[i];
      end
    end
  end

  assign ERASE_SCOPE = scope_r;
  assign ERASE_ADDR = eaddr_r;
  assign OTP_LOCKED = otp_lock_r;
endmodule

// [hw/sfe_pkg.sv]
// shared constants and types for the serial flash spi front end
package sfe_pkg;
  localparam int ADDR_W = 21;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_BITS = 8;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = 256;
  localparam int CNT_W = 9;
  localparam int SECTORS = 32;
  localparam int SUBSECTORS = 16;
  localparam int SECT_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam int OTP_BYTES = 64;
  localparam int OTP_AW = 6;
  localparam logic [ADDR_W-1:0] OTP_LOCK_ADDR = 21'h000040;
  localparam int OTP_LOCK_BIT = 0;
  localparam logic [7:0] OTP_ERASED = 8'hff;
  localparam int FIFO_DEPTH_DEF = 16;
  // synchroniser lanes
  localparam int SYNC_W = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_HOLD_N = 2;
  localparam int PIN_IO0 = 3;
  localparam int PIN_IO1 = 4;
  // select resets low so one held low through reset is not seen as a fall
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h04;
  // instruction codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUTPUT_FAST_READ = 8'h3b;
  localparam logic [7:0] OP_OTP_AREA_READ_CMD = 8'h4b;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_DUAL_INPUT_FAST_PROGRAM = 8'ha2;
  localparam logic [7:0] OP_OTP_AREA_PROGRAM_CMD = 8'h42;
  localparam logic [7:0] OP_SUB_ERASE = 8'h20;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_STATUS = 8'h05;
  // erase scopes
  localparam logic [1:0] SCOPE_SUB = 2'h0;
  localparam logic [1:0] SCOPE_SECT = 2'h1;
  localparam logic [1:0] SCOPE_BULK = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_RDATA = 3'b100,
    ST_WDATA = 3'b101,
    ST_DONE = 3'b110
  } sfe_state_e;
endpackage

// [hw/sfe_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule

// [hw/sfe_fifo.sv]
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module sfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid && (cnt_r != FULL);
    pop = out_ready && (cnt_r != '0);
    wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
    rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // one storage word per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk) begin
      if (push && (wr_r == AW'(i))) begin
        mem_r[i] <= in_data;
      end
    end
  end
endmodule

// [verification/sfe_assertions.sv]
// concurrent checks on the flash front end pins
`timescale 1ns/1ps
module sfe_assertions (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SPI_CLK,
  input wire logic CHIP_SEL_N,
  input wire logic HOLD_N,
  input wire logic BUSY,
  input wire logic SERIAL_IN_IO0_OE,
  input wire logic SERIAL_OUT_IO1_O,
  input wire logic SERIAL_OUT_IO1_OE,
  input wire logic ERASE_REQ,
  input wire logic [1:0] ERASE_SCOPE,
  input wire logic [sfe_pkg::ADDR_W-1:0] ERASE_ADDR,
  input wire logic OTP_LOCKED,
  input wire logic ACTIVE_POWER
);
  import sfe_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_desel_float;
    CHIP_SEL_N [*4] |-> !SERIAL_OUT_IO1_OE && !SERIAL_IN_IO0_OE;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("output driven while deselected");
  property p_hold_float;
    (!HOLD_N && !CHIP_SEL_N) [*4] |-> !SERIAL_OUT_IO1_OE;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("output driven during hold");
  property p_sel_active;
    !CHIP_SEL_N [*4] |-> ACTIVE_POWER;
  endproperty
  a_sel_active: assert property (p_sel_active)
    else $error("selected but not active");
  property p_busy_active;
    BUSY |=> ACTIVE_POWER;
  endproperty
  a_busy_active: assert property (p_busy_active)
    else $error("busy but not active");
  property p_io0_dual;
    SERIAL_IN_IO0_OE |-> SERIAL_OUT_IO1_OE;
  endproperty
  a_io0_dual: assert property (p_io0_dual)
    else $error("io0 driven without io1");
  property p_fall_shift;
    SERIAL_OUT_IO1_OE && $past(SERIAL_OUT_IO1_OE)
      && $changed(SERIAL_OUT_IO1_O) |-> !$past(SPI_CLK, 3);
  endproperty
  a_fall_shift: assert property (p_fall_shift)
    else $error("output bit changed away from clock fall");
  property p_erase_base;
    ERASE_REQ |-> CHIP_SEL_N && (ERASE_SCOPE == SCOPE_SUB ?
      ERASE_ADDR[11:0] == 12'h000 : ERASE_SCOPE == SCOPE_SECT ?
      ERASE_ADDR[15:0] == 16'h0000 : ERASE_ADDR == '0);
  endproperty
  a_erase_base: assert property (p_erase_base)
    else $error("erase base not aligned to scope");
  property p_otp_sticky;
    $past(OTP_LOCKED) |-> OTP_LOCKED;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky)
    else $error("otp lock released");
  c_erase: cover property (ERASE_REQ);
  c_dual_read: cover property (SERIAL_IN_IO0_OE);
  c_lock: cover property ($rose(OTP_LOCKED));
endmodule
bind sfe_front_end sfe_assertions i_chk (.CORE_CLK, .RESET_N, .SPI_CLK,
  .CHIP_SEL_N, .HOLD_N, .BUSY, .SERIAL_IN_IO0_OE, .SERIAL_OUT_IO1_O,
  .SERIAL_OUT_IO1_OE, .ERASE_REQ, .ERASE_SCOPE, .ERASE_ADDR, .OTP_LOCKED,
  .ACTIVE_POWER);

// [verification/sfe_spi_master.sv]
// spi bus master model that frames instructions on the pins
`timescale 1ns/1ps
module sfe_spi_master (
  input wire logic clk,
  input wire logic io0_i,
  input wire logic io1_i,
  output logic spi_clk,
  output logic cs_n,
  output logic io0_o,
  output logic io0_oe,
  output logic io1_o,
  output logic io1_oe
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    {io0_o, io0_oe, io1_o, io1_oe} = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sel();
    wt(4);
    cs_n <= 1'b0;
  endtask
  task automatic desel();
    wt(4);
    {io0_oe, io1_oe} <= 2'b00;
    cs_n <= 1'b1;
  endtask
  // msb first; dual puts the higher bit of each pair on io1
  task automatic put(input logic [7:0] b, input bit dual);
    for (int i = 7; i >= 0; i -= dual ? 2 : 1) begin
      io0_oe <= 1'b1;
      io0_o <= dual ? b[i-1] : b[i];
      io1_oe <= dual;
      io1_o <= b[i];
      wt(4);
      spi_clk <= 1'b1;
      wt(4);
      spi_clk <= 1'b0;
    end
  endtask
  task automatic get(output logic [7:0] b, input bit dual);
    {io0_oe, io1_oe} <= 2'b00;
    for (int i = 7; i >= 0; i -= dual ? 2 : 1) begin
      wt(4);
      b[i] = io1_i;
      if (dual) b[i-1] = io0_i;
      spi_clk <= 1'b1;
      wt(4);
      spi_clk <= 1'b0;
    end
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the serial flash front end
`timescale 1ns/1ps
module tb_top;
  import sfe_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold_n;
  logic busy;
  logic prog_ready;
  logic junk = 1'b0;
  logic [31:0] pv;
  logic [31:0] pn;
  logic [7:0] rd_byte;
  logic [7:0] b;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_ps = 0;
  int n_pe = 0;
  int n_er = 0;
  int n_rf = 0;
  wire io0, io1, sck, cs_n, m0, m0e, m1, m1e, d0, d0e, d1, d1e;
  wire rd_f, p_st, p_v, p_end, p_ov, er, lk, act, sb;
  wire [ADDR_W-1:0] rd_addr, p_addr, e_addr;
  wire [7:0] p_data;
  wire [1:0] e_scope;
  assign io0 = d0e ? d0 : m0e ? m0 : junk;
  assign io1 = d1e ? d1 : m1e ? m1 : junk;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    junk <= ~junk;
    rd_byte <= rd_addr[7:0] ^ 8'ha5;
    cyc <= cyc + 1;
    if (p_st) n_ps <= n_ps + 1;
    if (p_end) n_pe <= n_pe + 1;
    if (er) n_er <= n_er + 1;
    if (rd_f) n_rf <= n_rf + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  sfe_spi_master i_mst (.clk(clk), .io0_i(io0), .io1_i(io1), .spi_clk(sck),
    .cs_n(cs_n), .io0_o(m0), .io0_oe(m0e), .io1_o(m1), .io1_oe(m1e));
  sfe_front_end i_dut (.CORE_CLK(clk), .RESET_N(rst_n), .SPI_CLK(sck),
    .CHIP_SEL_N(cs_n), .HOLD_N(hold_n), .SERIAL_IN_IO0_I(io0),
    .SERIAL_IN_IO0_O(d0), .SERIAL_IN_IO0_OE(d0e), .SERIAL_OUT_IO1_I(io1),
    .SERIAL_OUT_IO1_O(d1), .SERIAL_OUT_IO1_OE(d1e), .PROT_VOLATILE(pv),
    .PROT_NONVOL(pn), .BUSY(busy), .RD_BYTE(rd_byte), .RD_FETCH(rd_f),
    .RD_ADDR(rd_addr), .PROG_START(p_st), .PROG_ADDR(p_addr),
    .PROG_DATA(p_data), .PROG_VALID(p_v), .PROG_READY(prog_ready),
    .PROG_END(p_end), .PROG_OVERRUN(p_ov), .ERASE_REQ(er),
    .ERASE_SCOPE(e_scope), .ERASE_ADDR(e_addr), .OTP_LOCKED(lk),
    .ACTIVE_POWER(act), .STANDBY(sb));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int n);
    i_mst.sel();
    i_mst.put(op, 0);
    for (int i = n - 1; i >= 0; i--) i_mst.put(a[i*8+:8], 0);
  endtask
  task automatic wren();
    hdr(OP_WRITE_EN, 24'h0, 0);
    i_mst.desel();
  endtask
  task automatic drain(input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++) begin
      chk("prog data", first + i, p_data);
      prog_ready <= 1'b1;
      @(posedge clk);
      prog_ready <= 1'b0;
      @(posedge clk);
    end
    chk("prog valid", 0, p_v);
  endtask
  task automatic s_start();
    i_mst.put(OP_WRITE_EN, 0);
    i_mst.desel();
    hdr(OP_PAGE_PROG, 24'h0, 3);
    i_mst.put(8'h11, 0);
    i_mst.desel();
    i_mst.wt(6);
    chk("starts", 0, n_ps);
  endtask
  task automatic s_prog();
    wren();
    hdr(OP_PAGE_PROG, 24'h012345, 3);
    chk("active", 1, act);
    for (int i = 0; i < 18; i++) i_mst.put(8'(8'h30 + i), 0);
    i_mst.desel();
    i_mst.wt(6);
    chk("starts", 1, n_ps);
    chk("prog addr", 32'h012345, p_addr);
    chk("overrun", 1, p_ov);
    drain(17, 8'h30);
    wren();
    hdr(OP_DUAL_INPUT_FAST_PROGRAM, 24'h0000f0, 3);
    i_mst.put(8'h9c, 1);
    i_mst.put(8'h9d, 1);
    i_mst.desel();
    i_mst.wt(6);
    chk("ends", 2, n_pe);
    drain(2, 8'h9c);
  endtask
  task automatic s_read();
    hdr(OP_READ, 24'h001234, 3);
    i_mst.get(b, 0);
    chk("read byte", 8'h91, b);
    i_mst.get(b, 0);
    chk("read byte", 8'h90, b);
    i_mst.wt(4);
    hold_n <= 1'b0;
    i_mst.wt(5);
    chk("hold oe", 0, d1e);
    hold_n <= 1'b1;
    i_mst.desel();
    i_mst.wt(5);
    chk("desel oe", 0, d1e);
    chk("fetches", 4, n_rf);
    hdr(OP_FAST_READ, 24'h000100, 3);
    i_mst.put(8'h00, 0);
    i_mst.get(b, 0);
    i_mst.desel();
    chk("fast byte", 8'ha5, b);
    hdr(OP_DUAL_OUTPUT_FAST_READ, 24'h000100, 3);
    i_mst.put(8'h00, 0);
    i_mst.get(b, 1);
    chk("dual byte", 8'ha5, b);
    i_mst.get(b, 1);
    chk("dual byte", 8'ha4, b);
    i_mst.desel();
  endtask
  task automatic s_erase();
    logic [7:0] ops [3] = '{OP_SUB_ERASE, OP_SECT_ERASE, OP_BULK_ERASE};
    logic [23:0] base [3] = '{24'h0ab000, 24'h0a0000, 24'h0};
    for (int k = 0; k < 5; k++) begin
      pn[10] <= (k == 3);
      pv[10] <= (k == 4);
      wren();
      hdr(ops[k%3], 24'h0abcde, k == 2 ? 0 : 3);
      i_mst.desel();
      i_mst.wt(6);
      chk("erase count", k < 3 ? k + 1 : 3, n_er);
      chk("erase scope", k % 3, e_scope);
      chk("erase base", base[k%3], e_addr);
    end
    pn <= '0;
    pv <= '0;
  endtask
  task automatic s_otp();
    logic [7:0] pgm [3] = '{8'h5a, 8'hfe, 8'h00};
    logic [23:0] oa [3] = '{24'h00, 24'h40, 24'h01};
    logic [7:0] want [3] = '{8'h5a, 8'h00, 8'hff};
    for (int k = 0; k < 3; k++) begin
      wren();
      hdr(OP_OTP_AREA_PROGRAM_CMD, oa[k], 3);
      i_mst.put(pgm[k], 0);
      i_mst.desel();
      i_mst.wt(6);
      chk("otp lock", k > 0, lk);
    end
    for (int k = 0; k < 3; k++) begin
      hdr(OP_OTP_AREA_READ_CMD, oa[k], 3);
      i_mst.put(8'h00, 0);
      i_mst.get(b, 0);
      i_mst.desel();
      chk("otp byte", want[k], b);
    end
  endtask
  task automatic s_busy();
    busy <= 1'b1;
    i_mst.wt(3);
    chk("busy active", 1, act);
    hdr(OP_WRITE_DIS, 24'h0, 0);
    i_mst.desel();
    hdr(OP_STATUS, 24'h0, 0);
    i_mst.get(b, 0);
    i_mst.desel();
    chk("status", 8'h05, b);
    busy <= 1'b0;
    i_mst.wt(5);
    chk("standby", 1, sb);
  endtask
  initial begin
    i_mst.cs_n <= 1'b0;
    {hold_n, busy, prog_ready} <= 3'b100;
    pv <= '0;
    pn <= '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_start();
    s_prog();
    s_read();
    s_erase();
    s_otp();
    s_busy();
    end_of_test();
  end
endmodule
